// ### bench/sap_host_model.sv
// Purpose: Serial host that selects, clocks and configures the port.
// Assumes: Each shift clock level lasts ten bus clocks.
// Notes:   After its own bits the host toggles data in, as a released wire.
`timescale 1ns/1ps
module sap_host_model (
  input  wire logic hclk,
  input  wire logic data_out,
  output logic      select_n_powerdown,
  output logic      shift_clock,
  output logic      data_in
);
  initial begin
    select_n_powerdown = 1'b1;
    shift_clock = 1'b0;
    data_in = 1'b0;
  end
  // Bit i of tx goes out before rise i+1; rx[i] is taken at rise i+1.
  task automatic xfer(input logic [7:0] tx, input int ntx, input int n,
                      output logic [39:0] rx);
    rx = '0;
    @(posedge hclk);
    select_n_powerdown <= 1'b0;
    data_in <= (ntx > 0) ? tx[0] : 1'b1;
    repeat (10) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      shift_clock <= 1'b1;
      rx[i] = data_out;
      repeat (10) @(posedge hclk);
      shift_clock <= 1'b0;
      data_in <= (i + 1 < ntx) ? tx[i+1] : ~data_in;
      repeat (10) @(posedge hclk);
    end
    select_n_powerdown <= 1'b1;
    repeat (10) @(posedge hclk);
  endtask
endmodule

// ### bench/sap_serial_port_bench.sv
// Purpose: Self-checking bench for the sampling converter serial port.
// Assumes: The comparator model lets the converter settle on a chosen code.
// Notes:   Streams are compared only from the null bit to the last clock.
`timescale 1ns/1ps
module sap_serial_port_bench
  import sap_pkg::*;
  ;
  logic                    hclk = 1'b0;
  logic                    hresetn = 1'b0;
  logic                    hsel = 1'b0;
  logic [31:0]             haddr = '0;
  logic [1:0]              htrans = '0;
  logic                    hwrite = 1'b0;
  logic [2:0]              hsize = SAP_HSIZE_WORD;
  logic [31:0]             hwdata = '0;
  logic                    hready;
  logic                    hreadyout, hresp;
  logic [31:0]             hrdata;
  logic                    select_n_powerdown, shift_clock, data_in;
  logic                    data_out, data_out_en, sample_enable, device_enabled;
  logic                    comparator_high = 1'b0;
  logic [SAP_RESULT_W-1:0] dac_code;
  logic                    single_ended_select, input_b_select, msb_only_order;
  logic                    bias_power_down, ref_high_impedance;
  logic [11:0]             target = '0;
  logic [39:0]             rx;
  logic [31:0]             rd;
  int                      fail_count = 0;
  int                      checked = 0;
  int                      cyc = 0;

  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) comparator_high <= (target >= dac_code);

  sap_serial_port u_dut (.*);
  sap_host_model u_host (.*);

  task automatic end_sim;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // The ceiling is about five and a half times the length of the planned run.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk_bits(input string what, input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= SAP_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  function automatic logic [39:0] expect_rx(int nul, logic only, logic [11:0] t);
    logic [39:0] e;
    e = '0;
    for (int k = 0; k < 12; k++) begin
      e[nul+1+k] = t[11-k];
      if (!only && k < 11) e[nul+13+k] = t[k+1];
    end
    return e;
  endfunction

  task automatic run(input string name, input logic two, input logic [2:0] cfg,
                     input int z, input int n, input logic [11:0] t);
    logic [7:0]  tx;
    logic [39:0] mask;
    int          nul;
    logic [31:0] cfg_rd;
    logic [2:0]  cfg_pins;
    target = t;
    ahb(1'b1, SAP_ADDR_CONTROL, {31'h0, two}, rd);
    tx = 8'({cfg, 1'b1}) << z;
    nul = two ? z + 4 : 2;
    fork
      u_host.xfer(tx, two ? z + 4 : 0, n, rx);
      begin
        @(posedge data_out_en);
        ahb(1'b0, SAP_ADDR_CONFIG, 32'h0, cfg_rd);
        cfg_pins = {msb_only_order, input_b_select, single_ended_select};
        chk_word("config", {29'h0, two ? cfg : 3'h0}, cfg_rd);
        chk_word("config pins", {29'h0, two ? cfg : 3'h0}, {29'h0, cfg_pins});
      end
    join
    mask = ~({40{1'b1}} << n) & ({40{1'b1}} << nul);
    chk_bits("stream", expect_rx(nul, two & cfg[2], t) & mask, rx & mask);
    ahb(1'b0, SAP_ADDR_STATUS, 32'h0, rd);
    chk_word("status", {13'h0, 1'b1, 1'b1, 1'b0, 4'h0, t}, rd);
    ahb(1'b0, SAP_ADDR_CONFIG, 32'h0, rd);
    chk_word("config cleared", 32'h0, rd);
    $display("test %s done", name);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b0, 8'h0C, 32'h0, rd);
    chk_word("unmapped", 32'h0, rd);
    run("single full", 1'b0, 3'h0, 0, 30, 12'hA5C);
    run("single abort", 1'b0, 3'h0, 0, 15, 12'h3C1);
    run("single again", 1'b0, 3'h0, 0, 28, 12'h001);
    for (int c = 0; c < 8; c++) begin
      run("two channel", 1'b1, 3'(c), c % 3, 34, 12'h800 ^ 12'(c * 273));
    end
    end_sim();
  end
endmodule

bind sap_serial_port sap_serial_port_sva u_sva (
  .hclk               (hclk),
  .hresetn            (hresetn),
  .hsel               (hsel),
  .htrans             (htrans),
  .hready             (hready),
  .hreadyout          (hreadyout),
  .hresp              (hresp),
  .hrdata             (hrdata),
  .select_n_powerdown (select_n_powerdown),
  .shift_clock        (shift_clock),
  .data_out           (data_out),
  .data_out_en        (data_out_en),
  .sample_enable      (sample_enable),
  .bias_power_down    (bias_power_down),
  .ref_high_impedance (ref_high_impedance),
  .device_enabled     (device_enabled)
);

// ### bench/sap_serial_port_sva.sv
// Purpose: Concurrent checks on the serial pins and bus answers.
// Assumes: The host holds each shift clock level for at least eight bus clocks.
// Notes:   Bound to the top module from the bench.
`timescale 1ns/1ps
module sap_serial_port_sva
  import sap_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        select_n_powerdown,
  input wire logic        shift_clock,
  input wire logic        data_out,
  input wire logic        data_out_en,
  input wire logic        sample_enable,
  input wire logic        bias_power_down,
  input wire logic        ref_high_impedance,
  input wire logic        device_enabled
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && hresp == SAP_HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  a_rdata_idle: assert property
    (!$past(hsel && hready && htrans == SAP_HTRANS_NONSEQ) |-> hrdata == '0)
    else $error("read data present without a request");
  a_off_floats: assert property (
    select_n_powerdown [*6] |-> !data_out_en && !device_enabled)
    else $error("output driven while deselected");
  a_off_powered: assert property (
    select_n_powerdown [*6] |-> bias_power_down && ref_high_impedance)
    else $error("powered while deselected");
  a_on_enabled: assert property (!select_n_powerdown [*6] |-> device_enabled)
    else $error("not enabled while selected");
  a_en_holds: assert property (data_out_en && !select_n_powerdown |=> data_out_en)
    else $error("output enable dropped inside a transfer");
  a_out_on_fall: assert property (
    $changed(data_out) |-> !shift_clock && !$past(shift_clock, 2))
    else $error("output changed away from a falling edge");
  a_null_first: assert property ($rose(data_out_en) |-> !shift_clock && !data_out)
    else $error("output enabled without a null bit on a fall");
  a_sample_up: assert property (
    sample_enable |-> !bias_power_down && !ref_high_impedance)
    else $error("sampling while powered down");
  a_sample_min: assert property ($rose(sample_enable) |=> sample_enable [*8])
    else $error("sampling window too short");
  a_sample_end: assert property ($fell(sample_enable) |-> data_out_en)
    else $error("sampling ended before the null bit");
endmodule

// ### hw/sap_pkg.sv
// Purpose: Shared constants and types of the sampling converter serial port.
// Assumes: One 200 MHz bus clock; serial pins are slow and asynchronous.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package sap_pkg;

  localparam int          SAP_RESULT_W        = 12;
  localparam int          SAP_CONFIG_BITS     = 3;
  localparam int          SAP_SYNC_STAGES     = 2;
  // Sampling lasts one and a half shift clocks, counted here as clock edges.
  localparam int          SAP_SAMPLE_HALVES   = 3;
  localparam logic [1:0]  SAP_SAMPLE_LAST     = 2'(SAP_SAMPLE_HALVES - 1);

  localparam logic [7:0]  SAP_ADDR_CONTROL    = 8'h00;
  localparam logic [7:0]  SAP_ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  SAP_ADDR_CONFIG     = 8'h08;

  localparam int          SAP_CTRL_TWO_CH     = 0;
  localparam logic        SAP_CTRL_RESET      = 1'b0;
  localparam int          SAP_STAT_RESULT     = 0;
  localparam int          SAP_STAT_BUSY       = 16;
  localparam int          SAP_STAT_VALID      = 17;
  localparam int          SAP_STAT_POWER_DOWN = 18;
  localparam int          SAP_CFG_SINGLE      = 0;
  localparam int          SAP_CFG_INPUT_B     = 1;
  localparam int          SAP_CFG_MSB_ONLY    = 2;

  localparam logic [1:0]  SAP_HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0]  SAP_HSIZE_WORD      = 3'h2;
  localparam logic        SAP_HRESP_OKAY      = 1'b0;

  typedef enum logic [2:0] {
    SAP_ST_OFF,
    SAP_ST_WAIT_START,
    SAP_ST_CONFIG,
    SAP_ST_SAMPLE,
    SAP_ST_MSB_OUT,
    SAP_ST_LSB_OUT,
    SAP_ST_ZEROS
  } sap_state_t;

endpackage

// ### hw/sap_sar_engine.sv
// Purpose: Successive approximation register, one decision per step.
// Assumes: The comparator answer is settled before each step arrives.
// Notes:   After the last step the code register holds the result.
`timescale 1ns/1ps
module sap_sar_engine #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic         step,
  input  wire logic         decided_bit,
  output logic      [W-1:0] code,
  output logic              last_step
);

  localparam int IW = $clog2(W);

  logic [IW-1:0] idx;

  assign last_step = (idx == '0);

  // Each step keeps or drops the trial bit and, except the last, raises the next one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code <= '0;
      idx  <= '0;
    end else if (start) begin
      code        <= '0;
      code[W-1]   <= 1'b1;
      idx         <= IW'(W - 1);
    end else if (step) begin
      code[idx] <= decided_bit;
      if (idx != '0) begin
        code[idx - 1'b1] <= 1'b1;
        idx              <= idx - 1'b1;
      end
    end
  end

endmodule

// ### hw/sap_serial_port.sv
// Purpose: Serial control and result port of a sampling converter.
// Assumes: Select, shift clock, data and comparator are asynchronous pins.
// Notes:   Software picks the variant; the choice is taken at select fall.
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Bits launch on shift clock falling edges, are sampled on rising edges.
// - Single-input: select fall starts; output enabled on second clock pulse.
// - Single-input: one null bit, then the result.
// - Select rise returns the single-input port to its initial state.
// - Two-channel is half duplex: config in first, result out afterwards.
// - Two-channel discards leading zeros; the first one is the start bit.
// - Three configuration bits follow the start bit and begin conversion.
// - After the configuration, input is ignored until select cycles.
// - Two-channel sends one null bit after configuration, then the result.
// - Configuration input is sampled on shift clock rising edges.
// - Mode bit one: second bit picks input a or b against ground.
// - Mode bit zero: differential; second bit picks which input is positive.
// - Ordering bit one: result MSB first, then zeros forever.
// - Ordering bit zero: MSB-first result then the same LSB first.
// - Single-input always sends MSB first then LSB first.
// - After the whole transfer, zeros are driven while select stays low.
// - After conversion, bias and comparator power down, reference floats.
// - Select high disables and powers down; select low enables.
// - Each conversion gives a twelve-bit result.
// - The input is sampled for one and a half shift clocks.
// - Shared wire: the line is driven low on the fourth fall after start.
module sap_serial_port
  import sap_pkg::*;
#(
  parameter int RESULT_W = SAP_RESULT_W
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic      [31:0]         hrdata,
  input  wire logic                select_n_powerdown,
  input  wire logic                shift_clock,
  input  wire logic                data_in,
  output logic                     data_out,
  output logic                     data_out_en,
  input  wire logic                comparator_high,
  output logic      [RESULT_W-1:0] dac_code,
  output logic                     sample_enable,
  output logic                     single_ended_select,
  output logic                     input_b_select,
  output logic                     msb_only_order,
  output logic                     bias_power_down,
  output logic                     ref_high_impedance,
  output logic                     device_enabled
);

  localparam int IW = $clog2(RESULT_W);

  if (RESULT_W < 2 || RESULT_W > 16) begin : g_bad_width
    $error("Result width must lie between 2 and 16 bits.");
  end

  logic [3:0]    pins_sync;
  logic          sel_s;
  logic          clk_s;
  logic          din_s;
  logic          cmp_s;
  logic          clk_prev;
  logic          rise;
  logic          fall;
  sap_state_t    state;
  logic          two_ch;
  logic          two_ch_mode;
  logic          cfg_cnt;
  logic [1:0]    edge_cnt;
  logic [IW-1:0] bit_idx;
  logic          null_edge;
  logic          sar_start;
  logic          sar_step;
  logic          sar_last;
  logic          conv_done;
  logic          result_valid;
  logic [RESULT_W-1:0] last_result;
  logic          dph_write;
  logic [7:0]    dph_addr;
  logic          aph_valid;
  logic [31:0]   read_word;

  // Select enters inverted so that the zero reset of the stage means deselected.
  sap_sync #(
    .W (4)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({comparator_high, data_in, shift_clock, ~select_n_powerdown}),
    .q     (pins_sync)
  );

  assign sel_s = ~pins_sync[0];
  assign clk_s = pins_sync[1];
  assign din_s = pins_sync[2];
  assign cmp_s = pins_sync[3];

  // Edges are found on the synchronised clock, so the pin's own edges are
  // seen two bus cycles late; the shift clock must be far slower than hclk.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_s;
    end
  end

  assign rise = clk_s & ~clk_prev;
  assign fall = ~clk_s & clk_prev;

  assign null_edge = (state == SAP_ST_SAMPLE) && fall
                     && (edge_cnt == SAP_SAMPLE_LAST);
  assign sar_start = null_edge;
  assign sar_step  = (state == SAP_ST_MSB_OUT) && fall;
  assign conv_done = sar_step && sar_last;

  sap_sar_engine #(
    .W (RESULT_W)
  ) u_sar (
    .clk         (hclk),
    .rst_n       (hresetn),
    .start       (sar_start),
    .step        (sar_step),
    .decided_bit (cmp_s),
    .code        (dac_code),
    .last_step   (sar_last)
  );

  // Transfer sequencing.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SAP_ST_OFF;
    end else if (sel_s) begin
      state <= SAP_ST_OFF;
    end else begin
      unique case (state)
        SAP_ST_OFF: begin
          state <= SAP_ST_WAIT_START;
        end
        SAP_ST_WAIT_START: begin
          if (rise && !two_ch) begin
            state <= SAP_ST_SAMPLE;
          end else if (rise && din_s) begin
            state <= SAP_ST_CONFIG;
          end
        end
        SAP_ST_CONFIG: begin
          if (rise && cfg_cnt) begin
            state <= SAP_ST_SAMPLE;
          end
        end
        SAP_ST_SAMPLE: begin
          if (null_edge) begin
            state <= SAP_ST_MSB_OUT;
          end
        end
        SAP_ST_MSB_OUT: begin
          if (conv_done && two_ch && msb_only_order) begin
            state <= SAP_ST_ZEROS;
          end else if (conv_done) begin
            state <= SAP_ST_LSB_OUT;
          end
        end
        SAP_ST_LSB_OUT: begin
          if (fall && bit_idx == IW'(RESULT_W - 1)) begin
            state <= SAP_ST_ZEROS;
          end
        end
        SAP_ST_ZEROS: begin
          state <= SAP_ST_ZEROS;
        end
      endcase
    end
  end

  // The variant is frozen for a whole exchange so a register write
  // during a transfer cannot corrupt it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      two_ch <= SAP_CTRL_RESET;
    end else if (state == SAP_ST_OFF) begin
      two_ch <= two_ch_mode;
    end
  end

  // Edge and bit counters.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_cnt  <= 1'b0;
      edge_cnt <= '0;
      bit_idx  <= '0;
    end else if (state == SAP_ST_OFF) begin
      cfg_cnt  <= 1'b0;
      edge_cnt <= '0;
      bit_idx  <= '0;
    end else begin
      if (state == SAP_ST_CONFIG && rise) begin
        cfg_cnt <= 1'b1;
      end
      if (state == SAP_ST_SAMPLE && (rise || fall)) begin
        edge_cnt <= edge_cnt + 2'h1;
      end
      if (conv_done) begin
        bit_idx <= IW'(1);
      end else if (state == SAP_ST_LSB_OUT && fall) begin
        bit_idx <= bit_idx + 1'b1;
      end
    end
  end

  // Configuration capture; input is only looked at in these windows.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      single_ended_select <= 1'b0;
      input_b_select      <= 1'b0;
      msb_only_order      <= 1'b0;
    end else if (state == SAP_ST_OFF) begin
      single_ended_select <= 1'b0;
      input_b_select      <= 1'b0;
      msb_only_order      <= 1'b0;
    end else if (two_ch && rise) begin
      if (state == SAP_ST_CONFIG && !cfg_cnt) begin
        single_ended_select <= din_s;
      end
      if (state == SAP_ST_CONFIG && cfg_cnt) begin
        input_b_select <= din_s;
      end
      if (state == SAP_ST_SAMPLE && edge_cnt == 2'h1) begin
        msb_only_order <= din_s;
      end
    end
  end

  // Serial output launch.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_out    <= 1'b0;
      data_out_en <= 1'b0;
    end else if (sel_s || state == SAP_ST_OFF) begin
      data_out    <= 1'b0;
      data_out_en <= 1'b0;
    end else if (fall) begin
      if (null_edge) begin
        data_out    <= 1'b0;
        data_out_en <= 1'b1;
      end else if (state == SAP_ST_MSB_OUT) begin
        data_out <= cmp_s;
      end else if (state == SAP_ST_LSB_OUT) begin
        data_out <= dac_code[bit_idx];
      end else if (state == SAP_ST_ZEROS) begin
        data_out <= 1'b0;
      end
    end
  end

  // Power control: the analog parts stay up from the wait for start through conversion.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_enable      <= 1'b0;
      bias_power_down    <= 1'b1;
      ref_high_impedance <= 1'b1;
      device_enabled     <= 1'b0;
    end else begin
      sample_enable      <= !sel_s && state == SAP_ST_SAMPLE;
      bias_power_down    <= sel_s || state == SAP_ST_OFF
                            || state == SAP_ST_LSB_OUT
                            || state == SAP_ST_ZEROS;
      ref_high_impedance <= sel_s || state == SAP_ST_OFF
                            || state == SAP_ST_LSB_OUT
                            || state == SAP_ST_ZEROS;
      device_enabled     <= !sel_s;
    end
  end

  // Result kept for software after each conversion.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_valid <= 1'b0;
      last_result  <= '0;
    end else if (conv_done) begin
      result_valid          <= 1'b1;
      last_result           <= dac_code;
      last_result[0]        <= cmp_s;
    end else if (state == SAP_ST_OFF && !sel_s) begin
      result_valid <= 1'b0;
    end
  end

  // Bus slave: zero wait states, every answer OKAY.
  assign aph_valid = hsel && hready && htrans == SAP_HTRANS_NONSEQ
                     && hsize == SAP_HSIZE_WORD;

  always_comb begin
    read_word = 32'h0000_0000;
    unique case (haddr[7:0])
      SAP_ADDR_CONTROL: begin
        read_word[SAP_CTRL_TWO_CH] = two_ch_mode;
      end
      SAP_ADDR_STATUS: begin
        read_word[SAP_STAT_RESULT +: RESULT_W] = last_result;
        read_word[SAP_STAT_BUSY]       = (state != SAP_ST_OFF);
        read_word[SAP_STAT_VALID]      = result_valid;
        read_word[SAP_STAT_POWER_DOWN] = bias_power_down;
      end
      SAP_ADDR_CONFIG: begin
        read_word[SAP_CFG_SINGLE]   = single_ended_select;
        read_word[SAP_CFG_INPUT_B]  = input_b_select;
        read_word[SAP_CFG_MSB_ONLY] = msb_only_order;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
    if (haddr[31:8] != 24'h00_0000) begin
      read_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_write <= 1'b0;
      dph_addr  <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      dph_write <= aph_valid && hwrite && haddr[31:8] == 24'h00_0000;
      dph_addr  <= haddr[7:0];
      hrdata    <= (aph_valid && !hwrite) ? read_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      two_ch_mode <= SAP_CTRL_RESET;
    end else if (dph_write && dph_addr == SAP_ADDR_CONTROL) begin
      two_ch_mode <= hwdata[SAP_CTRL_TWO_CH];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= SAP_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= SAP_HRESP_OKAY;
    end
  end

endmodule

// ### hw/sap_sync.sv
// Purpose: Two flip-flop synchroniser for a group of independent levels.
// Assumes: Each bit changes slowly against the clock.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module sap_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
